// *** epir_cfg.svh ***
// Constants of the external pin interrupt request block.
`ifndef EPIR_CFG_SVH
`define EPIR_CFG_SVH
`define EPIR_ADDR_W 4
`define EPIR_OFS_STATUS_CONTROL 4'h0
`define EPIR_OFS_IRQ_STATUS 4'h1
`define EPIR_OFS_IRQ_MASK 4'h2
`define EPIR_BIT_MODE 0
`define EPIR_BIT_IE 1
`define EPIR_BIT_ACK 2
`define EPIR_BIT_FLAG 3
`define EPIR_BIT_PE 4
`define EPIR_BIT_RSVD 5
`define EPIR_BIT_PDD 6
`define EPIR_CTRL_RESET 8'h00
`define EPIR_STATUS_BIT_EVENT 0
`endif

// *** epir_pkg.sv ***
// Types of the external pin interrupt request block.
package epir_pkg;
	typedef struct packed {
		logic [1:0] rst_sync;
		logic pin_meta;
		logic pin_sync;
		logic pin_prev;
		logic pin_function_enable;
		logic pull_device_disable;
		logic pin_event_flag;
		logic pin_interrupt_enable;
		logic detection_mode_select;
		logic evt_status;
		logic evt_mask;
		logic [7:0] rdata;
		logic irq_cpu;
		logic irq_sys;
		logic pullup_en;
	} epir_state_t;
endpackage : epir_pkg

// *** epir_top.sv ***
// External active-low interrupt pin detector with its status and control register.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "epir_cfg.svh"

//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (R1) Bit 4 enables the pin interrupt function; when 0 it is off.
// (R2) Bit 6 set turns the internal pullup off while the pin function is on.
// (R3) Bit 3 reads one when a pin event was detected, else zero.
// (R4) Writing one to bit 2 clears the flag; bit 2 always reads zero.
// (R5) In edge-and-level mode the flag cannot be cleared while the pin is low.
// (R6) Bit 1 set raises the processor request whenever the flag is set.
// (R7) Bit 0 selects falling edge only, or falling edge and low level.
// (R8) Software always writes zero into reserved bit 5.
// (R9) A high to low transition sets the flag; level mode holds it while low.
// (R10) The pin is synchronised first; no event while the function is disabled.
module epir_top
	import epir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic irq_pin_n,
	input wire logic [`EPIR_ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic irq_cpu,
	output logic irq_sys,
	output logic pullup_en
);

	epir_state_t s_r;
	epir_state_t s_nxt;

	function automatic logic [7:0] ctrl_view(input epir_state_t s);
		logic [7:0] v;
		v = 8'h00;
		v[`EPIR_BIT_MODE] = s.detection_mode_select;
		v[`EPIR_BIT_IE] = s.pin_interrupt_enable;
		v[`EPIR_BIT_FLAG] = s.pin_event_flag; // [R3]
		v[`EPIR_BIT_PE] = s.pin_function_enable;
		v[`EPIR_BIT_PDD] = s.pull_device_disable;
		return v; // [R4]
	endfunction : ctrl_view

	//////////////////////////////////////////////////////////////////////////////
	// Next state.
	always_comb begin
		logic sel_ctrl;
		logic fall;
		logic low;
		logic set_ev;
		logic ack;
		sel_ctrl = 1'b0;
		fall = 1'b0;
		low = 1'b0;
		set_ev = 1'b0;
		ack = 1'b0;
		s_nxt = s_r;
		s_nxt.rst_sync = {s_r.rst_sync[0], 1'b1};
		s_nxt.pin_meta = irq_pin_n; // [R10]
		s_nxt.pin_sync = s_r.pin_meta;
		s_nxt.pin_prev = s_r.pin_sync;
		sel_ctrl = addr == `EPIR_OFS_STATUS_CONTROL;
		fall = s_r.pin_prev & ~s_r.pin_sync; // [R9]
		low = ~s_r.pin_sync;
		set_ev = s_r.pin_function_enable & (fall | (s_r.detection_mode_select & low)); // [R7] [R10] [R1]
		ack = wr & sel_ctrl & wdata[`EPIR_BIT_ACK]; // [R4]
		if (wr && sel_ctrl) begin
			s_nxt.detection_mode_select = wdata[`EPIR_BIT_MODE];
			s_nxt.pin_interrupt_enable = wdata[`EPIR_BIT_IE];
			s_nxt.pin_function_enable = wdata[`EPIR_BIT_PE];
			s_nxt.pull_device_disable = wdata[`EPIR_BIT_PDD];
		end
		if (set_ev) begin
			s_nxt.pin_event_flag = 1'b1; // [R9] [R5]
		end else if (ack) begin
			s_nxt.pin_event_flag = 1'b0; // [R4]
		end
		if (set_ev) begin
			s_nxt.evt_status = 1'b1;
		end else if (wr && addr == `EPIR_OFS_IRQ_STATUS && wdata[`EPIR_STATUS_BIT_EVENT]) begin
			s_nxt.evt_status = 1'b0;
		end
		if (wr && addr == `EPIR_OFS_IRQ_MASK) begin
			s_nxt.evt_mask = wdata[`EPIR_STATUS_BIT_EVENT];
		end
		s_nxt.rdata = 8'h00;
		if (rd) begin
			case (addr)
				`EPIR_OFS_STATUS_CONTROL: s_nxt.rdata = ctrl_view(s_r);
				`EPIR_OFS_IRQ_STATUS: s_nxt.rdata = {7'h00, s_r.evt_status};
				`EPIR_OFS_IRQ_MASK: s_nxt.rdata = {7'h00, s_r.evt_mask};
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		s_nxt.irq_cpu = s_nxt.pin_event_flag & s_nxt.pin_interrupt_enable; // [R6]
		s_nxt.irq_sys = s_nxt.evt_status & s_nxt.evt_mask;
		s_nxt.pullup_en = s_nxt.pin_function_enable & ~s_nxt.pull_device_disable; // [R2]
	end

	//////////////////////////////////////////////////////////////////////////////
	// State register.
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s_r <= '0;
			s_r.pin_meta <= 1'b1;
			s_r.pin_sync <= 1'b1;
			s_r.pin_prev <= 1'b1;
		end else if (!s_r.rst_sync[1]) begin
			s_r <= '0;
			s_r.rst_sync <= s_nxt.rst_sync;
			s_r.pin_meta <= 1'b1;
			s_r.pin_sync <= 1'b1;
			s_r.pin_prev <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata = s_r.rdata;
	assign irq_cpu = s_r.irq_cpu;
	assign irq_sys = s_r.irq_sys;
	assign pullup_en = s_r.pullup_en;

endmodule : epir_top

// *** epir_props.sv ***
// Port checker.
`timescale 1ns/1ps
module epir_props (
	input logic clk_sys,
	input logic nrst,
	input logic irq_pin_n,
	input logic wr,
	input logic rd,
	input logic irq_cpu,
	input logic irq_sys,
	input logic pullup_en,
	input logic [3:0] addr,
	input logic [7:0] wdata,
	input logic [7:0] rdata
);
	logic [7:0] c;
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			c <= 8'h00;
		end else if (wr && addr == 4'h0) begin
			c <= wdata & 8'h53;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence s;
		$stable(c)[*4];
	endsequence
	a_pull_on: assert property (s |-> pullup_en == (c[4] & !c[6])) else $error("pullup level wrong");
	a_ie_gate: assert property (s ##0 !c[1] |-> !irq_cpu) else $error("request while disabled");
	a_pin_off: assert property (s ##0 !c[4] && !irq_cpu ##1 $stable(c) |-> !irq_cpu) else $error("pin off event");
	a_ack_rd: assert property (rd |=> !rdata[2]) else $error("ack bit read high");
	a_flag_rd: assert property (rd && addr == 4'h0 && irq_cpu |=> rdata[3]) else $error("flag not read");
	a_lvl_hold: assert property ((!irq_pin_n)[*8] ##0 s ##0 c == 8'h13 |-> irq_cpu) else $error("level lost");
	a_edge_set: assert property (s ##0 c[4] && c[1] && $fell(irq_pin_n) |-> ##[2:8] irq_cpu) else $error("edge missed");
	a_edge_clr: assert property ((!irq_pin_n)[*6] ##0 c == 8'h12 && wr && addr == 4'h0 && wdata == 8'h16 |-> ##3 !irq_cpu)
		else $error("edge flag kept");
	cover property (irq_cpu);
	cover property (irq_sys);
	cover property (rd ##1 rdata[3]);
	cover property (!pullup_en ##1 pullup_en);
endmodule : epir_props
bind epir_top epir_props u_epir_props(.*);

// *** epir_dev.sv ***
// Pin driver model.
`timescale 1ns/1ps
module epir_dev (
	input logic clk_sys,
	input logic req,
	output logic irq_pin_n = 1'b1
);
	always @(posedge clk_sys) begin
		irq_pin_n <= !req;
	end
endmodule : epir_dev

// *** tb_top.sv ***
// Bench.
`timescale 1ns/1ps
module tb_top;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic req = 1'b0;
	logic irq_pin_n;
	logic irq_cpu;
	logic irq_sys;
	logic pullup_en;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	int failures = 0;
	int n_checks = 0;
	epir_top u_epir_top (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.irq_pin_n(irq_pin_n),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.irq_cpu(irq_cpu),
		.irq_sys(irq_sys),
		.pullup_en(pullup_en)
	);
	epir_dev u_epir_dev (
		.clk_sys(clk_sys),
		.req(req),
		.irq_pin_n(irq_pin_n)
	);
	initial begin
		forever #25 clk_sys = !clk_sys;
	end
	task automatic c(input logic [7:0] seen, input logic [7:0] expd);
		n_checks++;
		if (seen !== expd) begin
			failures++;
			$display("CHECK FAILED %0t value mismatch", $time);
		end
	endtask : c
	task automatic x(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		if (!w) begin
			c(rdata, d);
		end
	endtask : x
	task automatic p;
		repeat (8) @(posedge clk_sys);
		#1;
	endtask : p
	task automatic give_verdict;
		if (failures == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#30000;
		failures++;
		give_verdict;
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1'b1;
		p;
		x(1'b0, 4'h0, 8'h00);
		x(1'b0, 4'hF, 8'h00);
		x(1'b1, 4'h0, 8'h57);
		c(pullup_en, 8'h00);
		x(1'b0, 4'h0, 8'h53);
		x(1'b1, 4'h0, 8'h12);
		p;
		c(pullup_en, 8'h01);
		req <= 1'b1;
		p;
		x(1'b0, 4'h0, 8'h1A);
		c(irq_cpu, 8'h01);
		x(1'b1, 4'h0, 8'h16);
		p;
		x(1'b0, 4'h0, 8'h12);
		x(1'b1, 4'h0, 8'h13);
		p;
		x(1'b1, 4'h0, 8'h17);
		x(1'b0, 4'h0, 8'h1B);
		req <= 1'b0;
		p;
		x(1'b1, 4'h0, 8'h17);
		x(1'b0, 4'h0, 8'h13);
		x(1'b1, 4'h0, 8'h02);
		req <= 1'b1;
		p;
		x(1'b0, 4'h0, 8'h02);
		x(1'b0, 4'h1, 8'h01);
		c(irq_sys, 8'h00);
		x(1'b1, 4'h2, 8'h01);
		p;
		c(irq_sys, 8'h01);
		x(1'b1, 4'h1, 8'h01);
		p;
		c(irq_sys, 8'h00);
		give_verdict;
	end
endmodule : tb_top
